// file: logic/hc_pkg.sv
`default_nettype none
package hc_pkg;

    // ----------------------------------------------------------------
    // Head geometry
    // ----------------------------------------------------------------
    localparam int NUM_DOTS = 256;
    localparam int DOT_W = 8;
    localparam int CODE_W = 4;
    localparam int LANES = 4;
    localparam int GROUPS = 4;
    localparam int DOTS_PER_GROUP = NUM_DOTS / GROUPS;
    localparam int PCT_W = 6;
    localparam logic [DOT_W-1:0] LAST_DOT = 8'hFF;

    // ----------------------------------------------------------------
    // Correction code table points
    // ----------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_MAX_UP = 4'h8;
    localparam logic signed [PCT_W-1:0] PCT_MAX_UP = 6'sh10;
    localparam logic [PCT_W-1:0] PCT_NEG_BIAS = 6'h20;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DOT_SEL = 8'h08;
    localparam logic [ADDR_W-1:0] REG_NV_CODE = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_ACTIVE = 8'h10;
    localparam logic [ADDR_W-1:0] REG_LINES = 8'h14;

    // Control fields.
    localparam int CTRL_LED_EN_BIT = 0;
    localparam int CTRL_CORR_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // Status fields.
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_RD_DONE_BIT = 2;
    localparam int STAT_DIR_DONE_BIT = 3;

    // Active-code readback fields.
    localparam int ACT_CODE_LSB = 0;
    localparam int ACT_PCT_LSB = 8;
    localparam int ACT_LIT_BIT = 16;

    // Read answer comes on the third cycle of a read request.
    localparam logic [1:0] RD_ANSWER_CNT = 2'h2;
    localparam logic [DOT_W-1:0] DOT_SEL_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_READ = 2'b01,
        MODE_DIRECT = 2'b10
    } hc_mode_t;

    typedef struct packed {
        logic shiftClk;
        logic latchPulse;
        logic [1:0] modeSel;
        logic [LANES-1:0] printDataBit;
        logic [GROUPS-1:0] groupDriveStrobeN;
    } hc_pins_t;

    typedef struct packed {
        logic [DOT_W-1:0] idx;
        logic lit;
        logic signed [PCT_W-1:0] pct;
    } hc_dot_t;

    // Maps a 4-bit code to its current step in percent.
    function automatic logic signed [PCT_W-1:0] hc_code_to_pct(input logic [CODE_W-1:0] code);
        logic [PCT_W-1:0] twice;
        twice = {1'b0, code, 1'b0};
        if (code == CODE_MAX_UP) begin
            hc_code_to_pct = PCT_MAX_UP;
        end else if (code[CODE_W-1]) begin
            hc_code_to_pct = $signed(twice - PCT_NEG_BIAS);
        end else begin
            hc_code_to_pct = $signed(twice);
        end
    endfunction

endpackage
`default_nettype wire

// file: logic/hc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module hc_sync
    import hc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_ff;

    // Two stages; only the second stage reads the first.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            meta_ff <= '0;
            syncOut <= '0;
        end else begin
            meta_ff <= asyncIn;
            syncOut <= meta_ff;
        end
    end

endmodule
`default_nettype wire

// file: logic/hc_corr_mem.sv
`timescale 1ns/1ps
`default_nettype none
module hc_corr_mem
    import hc_pkg::*;
#(
    parameter int WIDTH = CODE_W,
    parameter int DEPTH = NUM_DOTS,
    parameter int AW = DOT_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // Read port, data one cycle after the address
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData_ff
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Codes start at zero, which means no correction until loaded.
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = '0;
        end
    end

    // Write port; a plain always, because the initial block above also writes the array.
    always @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // Registered read port.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdData_ff <= '0;
        end else begin
            rdData_ff <= mem[rdAddr];
        end
    end

endmodule
`default_nettype wire

// file: logic/hc_led_head.sv
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module hc_led_head
    import hc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Avalon-MM register slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Head pins from the controller
    input wire logic shiftClk,
    input wire logic latchPulse,
    input wire logic [1:0] corrModeSel,
    input wire logic [LANES-1:0] printDataBit,
    input wire logic [GROUPS-1:0] groupDriveStrobeN,
    // Correction read-out towards the controller
    output logic [CODE_W-1:0] corrReadData,
    output logic corrReadOe,
    // LED array drive
    output logic [NUM_DOTS-1:0] ledOn,
    output hc_dot_t dotDrive
);

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    hc_pins_t pinsRaw;
    hc_pins_t pins;
    logic shiftPrev_ff;
    logic latchPrev_ff;
    wire logic shiftRise;
    wire logic latchRise;

    assign pinsRaw.shiftClk = shiftClk;
    assign pinsRaw.latchPulse = latchPulse;
    assign pinsRaw.modeSel = corrModeSel;
    assign pinsRaw.printDataBit = printDataBit;
    assign pinsRaw.groupDriveStrobeN = groupDriveStrobeN;

    // Data and clock share one synchroniser so they stay aligned.
    hc_sync #(
        .WIDTH($bits(hc_pins_t))
    ) u_pinSync (
        .sys_clk(sys_clk),
        .reset(reset),
        .asyncIn(pinsRaw),
        .syncOut(pins)
    );

    // Edge history reads the synchronised copy only.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            shiftPrev_ff <= 1'b0;
            latchPrev_ff <= 1'b0;
        end else begin
            shiftPrev_ff <= pins.shiftClk;
            latchPrev_ff <= pins.latchPulse;
        end
    end

    assign shiftRise = pins.shiftClk & ~shiftPrev_ff;
    assign latchRise = pins.latchPulse & ~latchPrev_ff;

    // ----------------------------------------------------------------
    // Mode selection
    // ----------------------------------------------------------------
    hc_mode_t mode_ff;
    hc_mode_t nxt_mode;
    wire logic enterRead;
    wire logic enterDirect;

    // A low latch line always means normal printing; reserved selects fall back too.
    always_comb begin
        nxt_mode = MODE_NORMAL;
        if (pins.latchPulse) begin
            case (pins.modeSel)
                2'h1: nxt_mode = MODE_READ;
                2'h2: nxt_mode = MODE_DIRECT;
                default: nxt_mode = MODE_NORMAL;
            endcase
        end
    end

    // Mode is power-on normal.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mode_ff <= MODE_NORMAL;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    assign enterRead = (nxt_mode == MODE_READ) && (mode_ff != MODE_READ);
    assign enterDirect = (nxt_mode == MODE_DIRECT) && (mode_ff != MODE_DIRECT);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [1:0] ctrl_ff;
    logic [DOT_W-1:0] dotSel_ff;
    logic readDone_ff;
    logic directDone_ff;
    logic [31:0] lineCount_ff;
    logic [1:0] rdCnt_ff;
    logic [31:0] avs_readdata_ff;
    wire logic ledEnable;
    wire logic corrEnable;

    assign ledEnable = ctrl_ff[CTRL_LED_EN_BIT];
    assign corrEnable = ctrl_ff[CTRL_CORR_EN_BIT];

    // Bus decode.
    wire logic [ADDR_W-1:0] wordAddr;
    wire logic selCtrl;
    wire logic selStatus;
    wire logic selDotSel;
    wire logic selNv;
    wire logic selActive;
    wire logic selLines;
    wire logic busNvRead;
    wire logic busActRead;
    wire logic statusClr;

    assign wordAddr = {avs_address[ADDR_W-1:2], 2'h0};
    assign selCtrl = (wordAddr == REG_CTRL);
    assign selStatus = (wordAddr == REG_STATUS);
    assign selDotSel = (wordAddr == REG_DOT_SEL);
    assign selNv = (wordAddr == REG_NV_CODE);
    assign selActive = (wordAddr == REG_ACTIVE);
    assign selLines = (wordAddr == REG_LINES);
    // The bus takes a memory read port only in the first cycle of its read.
    assign busNvRead = avs_read && (rdCnt_ff == 2'h0) && selNv;
    assign busActRead = avs_read && (rdCnt_ff == 2'h0) && selActive;
    assign statusClr = avs_write && selStatus && avs_byteenable[0];

    // ----------------------------------------------------------------
    // Correction memories
    // ----------------------------------------------------------------
    logic [DOT_W-1:0] readPtr_ff;
    logic [DOT_W-1:0] writePtr_ff;
    logic [DOT_W-1:0] scanIdx_ff;
    logic [DOT_W-1:0] scanIdxPrev_ff;
    logic nvBusPrev_ff;
    logic actBusPrev_ff;
    logic [CODE_W-1:0] nvQ;
    logic [CODE_W-1:0] actQ;
    wire logic nvWe;
    wire logic actWe;
    wire logic [DOT_W-1:0] nvRdAddr;
    wire logic [DOT_W-1:0] actRdAddr;

    // Nonvolatile code store, programmed by software and streamed out in read mode.
    assign nvWe = avs_write && selNv && avs_byteenable[0];
    assign nvRdAddr = busNvRead ? dotSel_ff : readPtr_ff;

    hc_corr_mem u_nvStore (
        .sys_clk(sys_clk),
        .reset(reset),
        .wrEn(nvWe),
        .wrAddr(dotSel_ff),
        .wrData(avs_writedata[CODE_W-1:0]),
        .rdAddr(nvRdAddr),
        .rdData_ff(nvQ)
    );

    // Active per-dot codes, only loaded in direct mode.
    assign actWe = (mode_ff == MODE_DIRECT) && shiftRise;
    assign actRdAddr = busActRead ? dotSel_ff : scanIdx_ff;

    hc_corr_mem u_activeCodes (
        .sys_clk(sys_clk),
        .reset(reset),
        .wrEn(actWe),
        .wrAddr(writePtr_ff),
        .wrData(pins.printDataBit),
        .rdAddr(actRdAddr),
        .rdData_ff(actQ)
    );

    // ----------------------------------------------------------------
    // Read-out and direct load pointers
    // ----------------------------------------------------------------
    // The controller must finish a read-out before direct load; the head only reports it.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            readPtr_ff <= '0;
            writePtr_ff <= '0;
        end else begin
            if (enterRead) begin
                readPtr_ff <= '0;
            end else if ((mode_ff == MODE_READ) && shiftRise) begin
                readPtr_ff <= readPtr_ff + 8'h01;
            end
            if (enterDirect) begin
                writePtr_ff <= '0;
            end else if (actWe) begin
                writePtr_ff <= writePtr_ff + 8'h01;
            end
        end
    end

    // Done flags: hardware set wins over a software clear in the same cycle.
    wire logic readEnds;
    wire logic directEnds;

    assign readEnds = (mode_ff == MODE_READ) && shiftRise && (readPtr_ff == LAST_DOT);
    assign directEnds = actWe && (writePtr_ff == LAST_DOT);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            readDone_ff <= 1'b0;
            directDone_ff <= 1'b0;
        end else begin
            if (readEnds) begin
                readDone_ff <= 1'b1;
            end else if (enterRead || (statusClr && avs_writedata[STAT_RD_DONE_BIT])) begin
                readDone_ff <= 1'b0;
            end
            if (directEnds) begin
                directDone_ff <= 1'b1;
            end else if (enterDirect || (statusClr && avs_writedata[STAT_DIR_DONE_BIT])) begin
                directDone_ff <= 1'b0;
            end
        end
    end

    // Read-out pins hold the code of the current pointer; bus reads of the code store skip a refresh.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            nvBusPrev_ff <= 1'b0;
            corrReadData <= '0;
            corrReadOe <= 1'b0;
        end else begin
            nvBusPrev_ff <= busNvRead;
            corrReadOe <= (mode_ff == MODE_READ);
            if (!nvBusPrev_ff) begin
                corrReadData <= nvQ;
            end
        end
    end

    // ----------------------------------------------------------------
    // Print data path
    // ----------------------------------------------------------------
    logic [NUM_DOTS-1:0] shiftReg_ff;
    logic [NUM_DOTS-1:0] latched_ff;
    logic [NUM_DOTS-1:0] nxt_ledOn;
    wire logic normalShift;
    wire logic normalLatch;

    assign normalShift = (mode_ff == MODE_NORMAL) && shiftRise;
    assign normalLatch = (nxt_mode == MODE_NORMAL) && latchRise;

    // Four lanes enter per shift edge; the first group shifted ends at the top.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            shiftReg_ff <= '0;
            latched_ff <= '0;
            lineCount_ff <= '0;
        end else begin
            if (normalShift) begin
                shiftReg_ff <= {shiftReg_ff[NUM_DOTS-LANES-1:0], pins.printDataBit};
            end
            if (normalLatch) begin
                latched_ff <= shiftReg_ff;
                lineCount_ff <= lineCount_ff + 32'h00000001;
            end
        end
    end

    // Each group lights only while its strobe is low; a controller that strobes
    // during loading shows old data, since the latch alone feeds the LEDs.
    for (genvar g = 0; g < GROUPS; g++) begin : gen_group
        assign nxt_ledOn[g*DOTS_PER_GROUP +: DOTS_PER_GROUP] =
            latched_ff[g*DOTS_PER_GROUP +: DOTS_PER_GROUP]
            & {DOTS_PER_GROUP{~pins.groupDriveStrobeN[g] & ledEnable}};
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ledOn <= '0;
        end else begin
            ledOn <= nxt_ledOn;
        end
    end

    // ----------------------------------------------------------------
    // Current trim scan
    // ----------------------------------------------------------------
    // One dot per cycle feeds the current DAC; a bus read of the active codes costs the scan one cycle.
    wire logic signed [PCT_W-1:0] scanPct;
    wire logic signed [PCT_W-1:0] actPct;

    assign actPct = hc_code_to_pct(actQ);
    assign scanPct = corrEnable ? actPct : '0;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            scanIdx_ff <= '0;
            scanIdxPrev_ff <= '0;
            actBusPrev_ff <= 1'b0;
            dotDrive <= '0;
        end else begin
            actBusPrev_ff <= busActRead;
            if (!busActRead) begin
                scanIdx_ff <= scanIdx_ff + 8'h01;
                scanIdxPrev_ff <= scanIdx_ff;
            end
            if (!actBusPrev_ff) begin
                dotDrive.idx <= scanIdxPrev_ff;
                dotDrive.lit <= ledOn[scanIdxPrev_ff];
                dotDrive.pct <= scanPct;
            end
        end
    end

    // ----------------------------------------------------------------
    // Avalon slave
    // ----------------------------------------------------------------
    logic [31:0] regRdData;

    // Read mux; unmapped words read as zero.
    always_comb begin
        regRdData = '0;
        if (selCtrl) begin
            regRdData[1:0] = ctrl_ff;
        end else if (selStatus) begin
            regRdData[STAT_MODE_LSB +: 2] = mode_ff;
            regRdData[STAT_RD_DONE_BIT] = readDone_ff;
            regRdData[STAT_DIR_DONE_BIT] = directDone_ff;
        end else if (selDotSel) begin
            regRdData[DOT_W-1:0] = dotSel_ff;
        end else if (selNv) begin
            regRdData[CODE_W-1:0] = nvQ;
        end else if (selActive) begin
            regRdData[ACT_CODE_LSB +: CODE_W] = actQ;
            regRdData[ACT_PCT_LSB +: PCT_W] = actPct;
            regRdData[ACT_LIT_BIT] = ledOn[dotSel_ff];
        end else if (selLines) begin
            regRdData = lineCount_ff;
        end
    end

    // Every read waits two cycles so the memory words are settled.
    assign avs_waitrequest = avs_read && (rdCnt_ff != RD_ANSWER_CNT);
    assign avs_readdata = avs_readdata_ff;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdCnt_ff <= '0;
            avs_readdata_ff <= '0;
        end else begin
            if (!avs_read || (rdCnt_ff == RD_ANSWER_CNT)) begin
                rdCnt_ff <= '0;
            end else begin
                rdCnt_ff <= rdCnt_ff + 2'h1;
            end
            if (avs_read && (rdCnt_ff == 2'h1)) begin
                avs_readdata_ff <= regRdData;
            end
        end
    end

    // Writes complete at once; only byte lane 0 carries live bits.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_ff <= CTRL_RESET;
            dotSel_ff <= DOT_SEL_RESET;
        end else if (avs_write && avs_byteenable[0]) begin
            if (selCtrl) begin
                ctrl_ff <= avs_writedata[1:0];
            end
            if (selDotSel) begin
                dotSel_ff <= avs_writedata[DOT_W-1:0];
            end
        end
    end

endmodule
`default_nettype wire

// file: sim/hc_led_head_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// Port checker
// ----------
module hc_led_head_props
    import hc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins and drive
    input wire logic latchPulse,
    input wire logic [1:0] corrModeSel,
    input wire logic [GROUPS-1:0] groupDriveStrobeN,
    input wire logic corrReadOe,
    input wire logic [NUM_DOTS-1:0] ledOn,
    input wire hc_dot_t dotDrive
);
    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Seven idle cycles leave room for the pin synchronisers.
    rd_answer_a: assert property ($rose(avs_read) |-> avs_waitrequest [*2] ##1 !avs_waitrequest)
        else $error("read answer out of step");
    wr_nowait_a: assert property (avs_write |-> !avs_waitrequest)
        else $error("write was stalled");
    rd_hold_a: assert property (!avs_read && !$past(avs_read) |-> $stable(avs_readdata))
        else $error("read data moved without a read");
    oe_off_a: assert property (!latchPulse [*7] |-> !corrReadOe)
        else $error("read-out driven outside read mode");
    all_dark_a: assert property ((groupDriveStrobeN == 4'hF) [*7] |-> ledOn == '0)
        else $error("dot lit with every strobe off");
    first_dark_a: assert property (groupDriveStrobeN[0] [*7] |-> ledOn[63:0] == '0)
        else $error("first group lit without its strobe");
    fourth_dark_a: assert property (groupDriveStrobeN[3] [*7] |-> ledOn[255:192] == '0)
        else $error("fourth group lit without its strobe");
    oe_on_a: assert property ((latchPulse && corrModeSel == 2'h1) [*7] |-> corrReadOe)
        else $error("read-out idle in read mode");
    lit_dark_a: assert property ((&groupDriveStrobeN) [*7] |-> !dotDrive.lit)
        else $error("scan reports a lit dot with every strobe off");
    idx_step_a: assert property ($changed(dotDrive.idx) |-> dotDrive.idx == $past(dotDrive.idx) + 8'h01)
        else $error("scan index skipped a dot");
    pct_range_a: assert property (!dotDrive.pct[0] && dotDrive.pct >= -14 && dotDrive.pct <= 16)
        else $error("current step off the table");
    cover property ($rose(avs_read));
    cover property ($rose(corrReadOe));
    cover property (|ledOn);
endmodule
`default_nettype wire

// file: sim/hc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// Printer controller on the head pins
// ----------
module hc_ctrl_model
    import hc_pkg::*;
(
    // Pins towards the head
    output var hc_pins_t pins,
    // Read-out from the head
    input wire logic [CODE_W-1:0] corrReadData
);
    logic [CODE_W-1:0] codeBuf [NUM_DOTS];
    // Strobes idle high; the shift clock stands still between frames.
    initial pins = 12'h00F;
    // Data changes while the clock is low and holds through the rise.
    task automatic edge_out(input logic [LANES-1:0] d);
        pins.printDataBit = d;
        #62.5;
        pins.shiftClk = 1'b1;
        #62.5;
        pins.shiftClk = 1'b0;
    endtask
    // Shift a whole line with strobes off, then pulse the latch.
    task automatic shift_line(input logic [NUM_DOTS-1:0] line);
        pins.groupDriveStrobeN = 4'hF;
        for (int k = 0; k < 64; k++) begin
            edge_out(line[NUM_DOTS-1-4*k -: 4]);
        end
        pins.printDataBit = ~pins.printDataBit;
        #62.5;
        pins.latchPulse = 1'b1;
        #62.5;
        pins.latchPulse = 1'b0;
    endtask
    task automatic set_strobes(input logic [GROUPS-1:0] s);
        pins.groupDriveStrobeN = s;
    endtask
    // Mode is set a period before the latch rises, so no print latch is seen.
    task automatic transfer(input logic dir);
        pins.modeSel = dir ? 2'b10 : 2'b01;
        #125;
        pins.latchPulse = 1'b1;
        #125;
        for (int i = 0; i < NUM_DOTS; i++) begin
            if (!dir) codeBuf[i] = corrReadData;
            edge_out(dir ? codeBuf[i] : ~pins.printDataBit);
        end
        #125;
        pins.latchPulse = 1'b0;
        #125;
        pins.modeSel = 2'b00;
    endtask
endmodule
`default_nettype wire

// file: sim/hc_led_head_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// Head testbench
// ----------
module hc_led_head_tb;
    import hc_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] adr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = '0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic waitReq;
    logic [CODE_W-1:0] corrData;
    logic corrOe;
    logic [NUM_DOTS-1:0] ledOn;
    logic [NUM_DOTS-1:0] line;
    hc_dot_t dotDrive;
    hc_pins_t pins;
    logic [31:0] expQ [$];
    logic [3:0] key;
    int miscompares = 0;
    int n_checks = 0;
    localparam logic [5:0] PCT [16] = '{6'h00, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E,
        6'h10, 6'h32, 6'h34, 6'h36, 6'h38, 6'h3A, 6'h3C, 6'h3E};
    hc_led_head i_hc_led_head (.sys_clk(sys_clk), .reset(reset), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitReq), .shiftClk(pins.shiftClk), .latchPulse(pins.latchPulse),
        .corrModeSel(pins.modeSel), .printDataBit(pins.printDataBit),
        .groupDriveStrobeN(pins.groupDriveStrobeN), .corrReadData(corrData), .corrReadOe(corrOe),
        .ledOn(ledOn), .dotDrive(dotDrive));
    hc_ctrl_model i_hc_ctrl_model (.pins(pins), .corrReadData(corrData));
    initial forever #4 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_line(input logic [NUM_DOTS-1:0] got, input logic [NUM_DOTS-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: lit dots %h expected %h", $time, got, exp);
        end
    endtask
    // The request holds until waitrequest is seen low at a rising edge.
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge sys_clk);
        end while (waitReq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rd_exp(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic strobe_chk(input logic [GROUPS-1:0] s, input logic [NUM_DOTS-1:0] e);
        i_hc_ctrl_model.set_strobes(s);
        repeat (10) @(negedge sys_clk);
        chk_line(ledOn, e);
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Each read answer takes the oldest note off the queue.
    always @(posedge sys_clk) begin
        if (rd === 1'b1 && waitReq === 1'b0) chk(rdata, expQ.pop_front());
    end
    // A hang ends long after the run of roughly 85 us should be over.
    initial begin
        #400us;
        chk(32'h0, 32'h1);
        final_report();
    end
    initial begin
        void'($urandom(32'h181C));
        key = 4'($urandom);
        for (int i = 0; i < NUM_DOTS; i++) line[i] = 1'($urandom);
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        rd_exp(REG_CTRL, 32'h3);
        rd_exp(REG_STATUS, 32'h0);
        rd_exp(8'h18, 32'h0);
        be <= 4'hE;
        bus(1'b1, REG_CTRL, 32'h0);
        be <= 4'hF;
        rd_exp(REG_CTRL, 32'h3);
        $display("Test reset done");
        for (int i = 0; i < NUM_DOTS; i++) begin
            bus(1'b1, REG_DOT_SEL, 32'(i));
            bus(1'b1, REG_NV_CODE, {28'h0, 4'(i) ^ key});
        end
        rd_exp(REG_NV_CODE, {28'h0, 4'hF ^ key});
        i_hc_ctrl_model.transfer(1'b0);
        for (int i = 0; i < NUM_DOTS; i++) begin
            chk({28'h0, i_hc_ctrl_model.codeBuf[i]}, {28'h0, 4'(i) ^ key});
        end
        rd_exp(REG_STATUS, 32'h4);
        i_hc_ctrl_model.transfer(1'b1);
        rd_exp(REG_STATUS, 32'hC);
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, REG_DOT_SEL, 32'(i));
            rd_exp(REG_ACTIVE, {18'h0, PCT[4'(i) ^ key], 4'h0, 4'(i) ^ key});
        end
        bus(1'b1, REG_CTRL, 32'h1);
        rd_exp(REG_ACTIVE, {18'h0, PCT[4'hF ^ key], 4'h0, 4'hF ^ key});
        chk({26'h0, dotDrive.pct}, 32'h0);
        bus(1'b1, REG_CTRL, 32'h3);
        $display("Test correction done");
        i_hc_ctrl_model.shift_line(line);
        rd_exp(REG_LINES, 32'h1);
        for (int g = 0; g < GROUPS; g++) begin
            strobe_chk(~(4'h1 << g), line & ({192'h0, {64{1'b1}}} << (64 * g)));
        end
        strobe_chk(4'h0, line);
        bus(1'b1, REG_DOT_SEL, 32'hFF);
        rd_exp(REG_ACTIVE, {15'h0, line[255], 2'h0, PCT[4'hF ^ key], 4'h0, 4'hF ^ key});
        strobe_chk(4'hF, '0);
        $display("Test printing done");
        final_report();
    end
endmodule
bind hc_led_head hc_led_head_props i_hc_led_head_props (.sys_clk(sys_clk), .reset(reset),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .latchPulse(latchPulse), .groupDriveStrobeN(groupDriveStrobeN),
    .corrModeSel(corrModeSel), .corrReadOe(corrReadOe), .ledOn(ledOn), .dotDrive(dotDrive));
`default_nettype wire
